// File: verilog/sgps_pkg.sv
// Constants shared by the switchgear position supervisor
package sgps_pkg;

	// Clock and supervision tick
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Travel timer width in bits; the timer counts ticks
	localparam int TIMER_W = 16;

	// Switch units of a withdrawable assembly
	localparam int UNITS = 2;
	localparam int ELEMENT = 0;
	localparam int TRUCK = 1;

	// Validated position codes
	localparam logic [1:0] POS_INDETERM = 2'h0;
	localparam logic [1:0] POS_OFF = 2'h1;
	localparam logic [1:0] POS_ON = 2'h2;
	localparam logic [1:0] POS_DISTURB = 2'h3;

	// Values after reset
	localparam logic [1:0] RESET_POS = POS_INDETERM;
	localparam logic RESET_REMOVED = 1'b0;

	// Travel state of one switch unit
	typedef enum logic [1:0] {
		RUN_IDLE,
		RUN_MOVE_ON,
		RUN_MOVE_OFF
	} sgps_run_type;

endpackage

// File: verilog/sgps_sync.sv
// Two-flop synchroniser for contact and plug inputs
`timescale 1ns/100ps
`default_nettype none
module sgps_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Asynchronous input and synchronised output
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sgps_sync_state_type;

	sgps_sync_state_type st;
	sgps_sync_state_type next_st;

	generate
		if (W < 1) begin : g_chk
			$error("sgps_sync: width must be at least one");
		end
	endgenerate

	always_comb begin
		next_st = st;
		next_st.meta = d;
		next_st.sync = st.meta;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.sync;

endmodule
`default_nettype wire

// File: verilog/sgps_supervisor.sv
// Position supervisor for a withdrawable switch assembly (element and truck)
//
// Behaviour
// - Position is a two-bit code: 0 indeterminate, 1 open, 2 closed, 3 disturbed.
// - Contacts are sampled continuously; position is qualified by the travel timers.
// - Close starts close timer, indeterminate while running; closed or disturbed at end.
// - Open starts open timer, indeterminate while running; open or disturbed at end.
// - Contacts 0/1 decode as open, 1/0 decode as closed.
// - Equal contacts: indeterminate while timing, disturbed once the timer expired.
// - Command output lasts at most one tick over the travel time, ends early on new position.
// - One wired contact gives no disagreement check, only command-to-feedback timing.
// - Withdrawable unit is two switch units, element and truck, each with timers.
// - Plug removed forces the element into removed state reporting open.
// - Commands and position changes for a removed element are ignored.
// - Protection commands may optionally share the ordinary command relays.
// - Single-contact unit with no contact assigned reports disturbed.
`timescale 1ns/100ps
`default_nettype none
module sgps_supervisor
	import sgps_pkg::*;
#(
	parameter int TICK_CYCLES_P = sgps_pkg::TICK_CYCLES,
	parameter int TW = sgps_pkg::TIMER_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Auxiliary contacts from the switchgear, per unit, and the plug contact
	input wire logic [sgps_pkg::UNITS-1:0] aux_closed,
	input wire logic [sgps_pkg::UNITS-1:0] aux_open,
	input wire logic plug_removed,
	// Contact wiring configuration, per unit
	input wire logic [sgps_pkg::UNITS-1:0] wired_closed,
	input wire logic [sgps_pkg::UNITS-1:0] wired_open,
	// Travel times in ticks, per unit
	input wire logic [sgps_pkg::UNITS-1:0][TW-1:0] t_move_on,
	input wire logic [sgps_pkg::UNITS-1:0][TW-1:0] t_move_off,
	// Control and protection commands, one-cycle requests
	input wire logic [sgps_pkg::UNITS-1:0] ctl_close,
	input wire logic [sgps_pkg::UNITS-1:0] ctl_open,
	input wire logic prot_close,
	input wire logic prot_open,
	// Options
	input wire logic prot_share_en,
	input wire logic interlock_en,
	// Command relays
	output logic [sgps_pkg::UNITS-1:0] close_cmd,
	output logic [sgps_pkg::UNITS-1:0] open_cmd,
	output logic prot_close_relay,
	output logic prot_open_relay,
	// Validated position, per unit, and the removed flag
	output logic [sgps_pkg::UNITS-1:0][1:0] pos,
	output logic [sgps_pkg::UNITS-1:0] pos_on,
	output logic [sgps_pkg::UNITS-1:0] pos_off,
	output logic [sgps_pkg::UNITS-1:0] pos_indeterm,
	output logic [sgps_pkg::UNITS-1:0] pos_disturb,
	output logic removed
);
	import sgps_pkg::*;

	localparam int PW = (TICK_CYCLES_P > 1) ? $clog2(TICK_CYCLES_P) : 1;
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES_P - 1);

	typedef struct packed {
		logic [PW-1:0] pre;
		logic tick;
		sgps_run_type [UNITS-1:0] run;
		logic [UNITS-1:0][TW-1:0] cnt;
		logic [UNITS-1:0] fault;
		logic [UNITS-1:0] fault_to_on;
		logic [UNITS-1:0][1:0] pos;
		logic [UNITS-1:0] close_cmd;
		logic [UNITS-1:0] open_cmd;
		logic prot_close_relay;
		logic prot_open_relay;
		logic removed;
	} sgps_state_type;

	sgps_state_type st;
	sgps_state_type next_st;

	logic [UNITS-1:0] closed_s;
	logic [UNITS-1:0] open_s;
	logic removed_s;
	logic [UNITS-1:0][1:0] raw;
	logic [UNITS-1:0] cl_eff;
	logic [UNITS-1:0] op_eff;

	generate
		if (TICK_CYCLES_P < 1 || TW < 1) begin : g_chk
			$error("sgps_supervisor: tick and timer width must be at least one");
		end
	endgenerate

	sgps_sync #(
		.W(2 * UNITS + 1)
	) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.d({plug_removed, aux_open, aux_closed}),
		.q({removed_s, open_s, closed_s})
	);

	// Contact decode; ambiguous gives indeterminate, nothing wired gives disturbed
	function automatic logic [1:0] contact_pos(input logic c, input logic o,
			input logic wc, input logic wo);
		logic [1:0] r;
		r = POS_INDETERM;
		if (wc && wo) begin
			if (c && !o) begin
				r = POS_ON;
			end else if (!c && o) begin
				r = POS_OFF;
			end else begin
				r = POS_INDETERM;
			end
		end else if (wc) begin
			r = c ? POS_ON : POS_OFF;
		end else if (wo) begin
			r = o ? POS_OFF : POS_ON;
		end else begin
			r = POS_DISTURB;
		end
		return r;
	endfunction

	always_comb begin
		next_st = st;
		raw = '0;
		cl_eff = '0;
		op_eff = '0;

		// Supervision tick
		next_st.tick = 1'b0;
		if (st.pre == PRE_LAST) begin
			next_st.pre = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.pre = st.pre + 1'b1;
		end

		next_st.removed = removed_s;

		// Protection commands on separate relays unless shared
		next_st.prot_close_relay = prot_close & ~prot_share_en & ~removed_s;
		next_st.prot_open_relay = prot_open & ~prot_share_en & ~removed_s;

		for (int u = 0; u < UNITS; u++) begin
			raw[u] = contact_pos(closed_s[u], open_s[u], wired_closed[u], wired_open[u]);
			cl_eff[u] = ctl_close[u];
			op_eff[u] = ctl_open[u];
			if (u == ELEMENT) begin
				cl_eff[u] = cl_eff[u] | (prot_share_en & prot_close);
				op_eff[u] = op_eff[u] | (prot_share_en & prot_open);
				if (removed_s) begin
					cl_eff[u] = 1'b0;
					op_eff[u] = 1'b0;
				end
			end
			if (u == TRUCK && interlock_en && st.pos[ELEMENT] == POS_ON) begin
				op_eff[u] = 1'b0;
			end

			unique case (st.run[u])
				RUN_IDLE: begin
					if (st.fault[u] && raw[u] == (st.fault_to_on[u] ? POS_ON : POS_OFF)) begin
						next_st.fault[u] = 1'b0;
					end
					if (cl_eff[u] && !op_eff[u]) begin
						next_st.run[u] = RUN_MOVE_ON;
						next_st.cnt[u] = t_move_on[u];
						next_st.fault[u] = 1'b0;
					end else if (op_eff[u] && !cl_eff[u]) begin
						next_st.run[u] = RUN_MOVE_OFF;
						next_st.cnt[u] = t_move_off[u];
						next_st.fault[u] = 1'b0;
					end
				end
				RUN_MOVE_ON: begin
					if (raw[u] == POS_ON) begin
						next_st.run[u] = RUN_IDLE;
					end else if (st.tick) begin
						if (st.cnt[u] == '0) begin
							next_st.run[u] = RUN_IDLE;
							next_st.fault[u] = 1'b1;
							next_st.fault_to_on[u] = 1'b1;
						end else begin
							next_st.cnt[u] = st.cnt[u] - 1'b1;
						end
					end
				end
				RUN_MOVE_OFF: begin
					if (raw[u] == POS_OFF) begin
						next_st.run[u] = RUN_IDLE;
					end else if (st.tick) begin
						if (st.cnt[u] == '0) begin
							next_st.run[u] = RUN_IDLE;
							next_st.fault[u] = 1'b1;
							next_st.fault_to_on[u] = 1'b0;
						end else begin
							next_st.cnt[u] = st.cnt[u] - 1'b1;
						end
					end
				end
				default: begin
					next_st.run[u] = RUN_IDLE;
				end
			endcase

			// A removed element is frozen in the open position
			if (u == ELEMENT && removed_s) begin
				next_st.run[u] = RUN_IDLE;
				next_st.fault[u] = 1'b0;
			end

			if (u == ELEMENT && removed_s) begin
				next_st.pos[u] = POS_OFF;
			end else if (next_st.run[u] != RUN_IDLE) begin
				next_st.pos[u] = POS_INDETERM;
			end else if (next_st.fault[u]) begin
				next_st.pos[u] = POS_DISTURB;
			end else begin
				next_st.pos[u] = raw[u];
			end

			next_st.close_cmd[u] = (next_st.run[u] == RUN_MOVE_ON);
			next_st.open_cmd[u] = (next_st.run[u] == RUN_MOVE_OFF);
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
			st.pos <= {UNITS{RESET_POS}};
			st.removed <= RESET_REMOVED;
		end else begin
			st <= next_st;
		end
	end

	assign close_cmd = st.close_cmd;
	assign open_cmd = st.open_cmd;
	assign prot_close_relay = st.prot_close_relay;
	assign prot_open_relay = st.prot_open_relay;
	assign pos = st.pos;
	assign removed = st.removed;

	generate
		for (genvar g = 0; g < UNITS; g++) begin : g_unit
			assign pos_on[g] = (st.pos[g] == POS_ON);
			assign pos_off[g] = (st.pos[g] == POS_OFF);
			assign pos_indeterm[g] = (st.pos[g] == POS_INDETERM);
			assign pos_disturb[g] = (st.pos[g] == POS_DISTURB);

			localparam bit IS_ELEM = (g == ELEMENT);

			close_indet_a: assert property (@(posedge sys_clk) disable iff (reset)
				close_cmd[g] |-> pos[g] == POS_INDETERM && !pos_on[g])
				else $error("close command without indeterminate position");

			open_indet_a: assert property (@(posedge sys_clk) disable iff (reset)
				open_cmd[g] |-> pos[g] == POS_INDETERM && !pos_off[g])
				else $error("open command without indeterminate position");

			cmd_excl_a: assert property (@(posedge sys_clk) disable iff (reset)
				!(close_cmd[g] && open_cmd[g]))
				else $error("close and open commands together");

			cmd_expiry_a: assert property (@(posedge sys_clk) disable iff (reset)
				(st.run[g] != RUN_IDLE && st.tick && st.cnt[g] == '0)
				|=> !close_cmd[g] && !open_cmd[g])
				else $error("command outlived its travel time");

			timeout_fault_a: assert property (@(posedge sys_clk) disable iff (reset)
				(st.run[g] == RUN_MOVE_ON && st.tick && st.cnt[g] == '0
				&& raw[g] != POS_ON && !(IS_ELEM && removed_s))
				|=> pos[g] == POS_DISTURB ##1 pos[g] == POS_DISTURB || close_cmd[g] || open_cmd[g])
				else $error("travel timeout did not give disturbed");

			feedback_end_a: assert property (@(posedge sys_clk) disable iff (reset)
				(st.run[g] == RUN_MOVE_ON && raw[g] == POS_ON && !(IS_ELEM && removed_s))
				|=> !close_cmd[g] && pos[g] == POS_ON)
				else $error("closed feedback did not end the close command");

			decode_closed_a: assert property (@(posedge sys_clk) disable iff (reset)
				(st.run[g] == RUN_IDLE && !st.fault[g] && !cl_eff[g] && !op_eff[g]
				&& wired_closed[g] && wired_open[g] && closed_s[g] && !open_s[g]
				&& !(IS_ELEM && removed_s))
				|=> pos[g] == POS_ON)
				else $error("closed contacts not decoded as closed");

			none_wired_a: assert property (@(posedge sys_clk) disable iff (reset)
				(st.run[g] == RUN_IDLE && !cl_eff[g] && !op_eff[g] && !wired_closed[g]
				&& !wired_open[g] && !(IS_ELEM && removed_s))
				|=> pos[g] == POS_DISTURB)
				else $error("unwired unit not reported disturbed");
		end
	endgenerate

	removed_open_a: assert property (@(posedge sys_clk) disable iff (reset)
		removed_s |=> removed && pos[ELEMENT] == POS_OFF)
		else $error("removed element not reported open");

	removed_cmd_a: assert property (@(posedge sys_clk) disable iff (reset)
		removed |-> !close_cmd[ELEMENT] && !open_cmd[ELEMENT] && !prot_open_relay)
		else $error("command issued to removed element");

	withdraw_lock_a: assert property (@(posedge sys_clk) disable iff (reset)
		(interlock_en && pos[ELEMENT] == POS_ON && st.run[TRUCK] == RUN_IDLE)
		|=> !open_cmd[TRUCK])
		else $error("truck withdrawn with element closed");

endmodule
`default_nettype wire

// File: bench/sgps_gear.sv
// Behavioural switchgear: auxiliary contacts following the command relays
`timescale 1ns/100ps
`default_nettype none
module sgps_gear #(
	parameter int MOVE_CYCLES = 6
) (
	// Clock
	input wire logic sys_clk,
	// Command relays and a commanded jam
	input wire logic close_cmd,
	input wire logic open_cmd,
	input wire logic stuck,
	// Auxiliary contacts
	output logic aux_closed,
	output logic aux_open
);
	logic st = 1'b0;
	logic mid = 1'b0;
	int cnt = 0;

	always @(posedge sys_clk) begin
		if ((close_cmd && !st) || (open_cmd && st)) begin
			if (stuck) begin
				mid <= 1'b1;
			end else if (cnt == MOVE_CYCLES - 1) begin
				st <= ~st;
				cnt <= 0;
				mid <= 1'b0;
			end else begin
				cnt <= cnt + 1;
				mid <= 1'b1;
			end
		end else if (!stuck) begin
			mid <= 1'b0;
			cnt <= 0;
		end
	end

	// Both contacts open while the mechanism travels or jams
	assign aux_closed = mid ? 1'b0 : st;
	assign aux_open = mid ? 1'b0 : ~st;
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench of the switchgear position supervisor
`timescale 1ns/100ps
`default_nettype none
module tb
	import sgps_pkg::*;
;
	localparam int TK = 4;
	localparam int T = 4;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] aux_closed, aux_open, wired_closed, wired_open, ctl_close, ctl_open, stuck;
	logic [1:0][15:0] t_on, t_off;
	logic plug_removed, prot_close, prot_open, prot_share_en, interlock_en, removed;
	logic prot_close_relay, prot_open_relay;
	logic [1:0] close_cmd, open_cmd, pos_on, pos_off, pos_indeterm, pos_disturb;
	logic [1:0][1:0] pos;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;

	always #10 sys_clk = ~sys_clk;

	sgps_supervisor #(.TICK_CYCLES_P(TK), .TW(16)) uut (.sys_clk(sys_clk), .reset(reset),
		.aux_closed(aux_closed), .aux_open(aux_open), .plug_removed(plug_removed),
		.wired_closed(wired_closed), .wired_open(wired_open), .t_move_on(t_on),
		.t_move_off(t_off), .ctl_close(ctl_close), .ctl_open(ctl_open),
		.prot_close(prot_close), .prot_open(prot_open), .prot_share_en(prot_share_en),
		.interlock_en(interlock_en), .close_cmd(close_cmd), .open_cmd(open_cmd),
		.prot_close_relay(prot_close_relay), .prot_open_relay(prot_open_relay), .pos(pos),
		.pos_on(pos_on), .pos_off(pos_off), .pos_indeterm(pos_indeterm),
		.pos_disturb(pos_disturb), .removed(removed));

	for (genvar u = 0; u < 2; u++) begin : gear
		sgps_gear g (.sys_clk(sys_clk), .close_cmd(close_cmd[u]), .open_cmd(open_cmd[u]),
			.stuck(stuck[u]), .aux_closed(aux_closed[u]), .aux_open(aux_open[u]));
	end

	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	task automatic pulse(input int u, input logic cls);
		@(negedge sys_clk);
		if (cls) ctl_close[u] = 1'b1; else ctl_open[u] = 1'b1;
		@(negedge sys_clk);
		ctl_close = 2'h0;
		ctl_open = 2'h0;
		@(negedge sys_clk);
	endtask

	// Counts the cycles the unit's relay stays up
	task automatic wait_drop(input int u, output int cnt);
		cnt = 0;
		while ((close_cmd[u] | open_cmd[u]) === 1'b1 && cnt < 100) begin
			@(negedge sys_clk);
			cnt++;
		end
		@(negedge sys_clk);
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			$display("Error at %0t: timeout", $time);
			final_report();
		end
	end

	initial begin
		{wired_closed, wired_open} = 4'hf;
		{ctl_close, ctl_open, stuck} = 6'h00;
		{plug_removed, prot_close, prot_open, prot_share_en, interlock_en} = 5'h00;
		t_on = {16'h0004, 16'h0004};
		t_off = {16'h0004, 16'h0004};
		repeat (3) @(negedge sys_clk);
		chk(pos[0], POS_INDETERM);
		chk(close_cmd, 2'h0);
		reset = 1'b0;
		repeat (6) @(negedge sys_clk);
		chk(pos[0], POS_OFF);
		chk(pos[1], POS_OFF);
		done("decode");
		pulse(0, 1'b1);
		chk({close_cmd[0], pos_indeterm[0]}, 2'h3);
		chk(pos[0], POS_INDETERM);
		wait_drop(0, n);
		chk({1'b0, n <= (T + 1) * TK + 1}, 2'h1);
		chk(pos[0], POS_ON);
		done("close");
		stuck[1] = 1'b1;
		pulse(1, 1'b1);
		repeat (4) @(negedge sys_clk);
		chk(pos[1], POS_INDETERM);
		wait_drop(1, n);
		chk({1'b0, n >= T * TK - 6 && n <= (T + 1) * TK + 1}, 2'h1);
		chk({pos_disturb[1], pos_indeterm[1]}, 2'h2);
		chk(pos[1], POS_DISTURB);
		stuck[1] = 1'b0;
		repeat (4) @(negedge sys_clk);
		pulse(1, 1'b1);
		wait_drop(1, n);
		chk(pos[1], POS_ON);
		done("timeout");
		interlock_en = 1'b1;
		pulse(1, 1'b0);
		chk(open_cmd[1], 1'b0);
		interlock_en = 1'b0;
		pulse(1, 1'b0);
		wait_drop(1, n);
		chk(pos[1], POS_OFF);
		done("interlock");
		prot_share_en = 1'b1;
		prot_open = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk({open_cmd[0], prot_open_relay}, 2'h2);
		n = 0;
		while (pos[0] !== POS_OFF && n < 60) begin
			@(negedge sys_clk);
			n++;
		end
		prot_open = 1'b0;
		chk(pos[0], POS_OFF);
		prot_share_en = 1'b0;
		prot_close = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk({prot_close_relay, close_cmd[0]}, 2'h2);
		prot_close = 1'b0;
		done("protection");
		repeat (3) @(negedge sys_clk);
		pulse(0, 1'b1);
		wait_drop(0, n);
		plug_removed = 1'b1;
		repeat (5) @(negedge sys_clk);
		chk({removed, pos_off[0]}, 2'h3);
		chk(pos[0], POS_OFF);
		pulse(0, 1'b0);
		pulse(0, 1'b1);
		chk({close_cmd[0], open_cmd[0]}, 2'h0);
		chk(pos[0], POS_OFF);
		plug_removed = 1'b0;
		done("removed");
		wired_open[1] = 1'b0;
		repeat (5) @(negedge sys_clk);
		chk(pos[1], POS_OFF);
		stuck[1] = 1'b1;
		pulse(1, 1'b1);
		wait_drop(1, n);
		chk(pos[1], POS_DISTURB);
		stuck[1] = 1'b0;
		pulse(1, 1'b1);
		wait_drop(1, n);
		chk(pos_on[1], 1'b1);
		{wired_closed[1], wired_open[1]} = 2'h1;
		stuck[1] = 1'b1;
		pulse(1, 1'b0);
		wait_drop(1, n);
		chk(pos[1], POS_DISTURB);
		stuck[1] = 1'b0;
		pulse(1, 1'b1);
		wait_drop(1, n);
		chk(pos_on[1], 1'b1);
		{wired_closed[1], wired_open[1]} = 2'h0;
		repeat (5) @(negedge sys_clk);
		chk(pos[1], POS_DISTURB);
		done("single contact");
		final_report();
	end
endmodule
`default_nettype wire
